// ==== tpg_generator.v ====
/*
 * Test pattern generator: register page, frame sequencer, byte engine
 * and output stage toward the csi-2 transmitter.
 * Assumes the indirect access logic presents one-cycle read and write
 * strobes with offset and data, and that the output rate code comes
 * from transmitter setup on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

`include "tpg_map.vh"

module tpg_generator (
  // clock and reset
  input  wire       clock,
  input  wire       srst,
  // indirect register page access
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // output rate code from transmitter setup
  input  wire [1:0] csi_rate_sel,
  // packet stream toward the csi-2 transmitter
  output reg        out_valid,
  input  wire       out_ready,
  output reg  [1:0] out_kind,
  output reg        out_first,
  output reg        out_last,
  output reg  [1:0] out_vc,
  output reg  [5:0] out_dt,
  output reg  [7:0] out_data,
  // frame status
  output reg        frame_active
);

  localparam [2:0] PH_IDLE = 3'h0;
  localparam [2:0] PH_FS   = 3'h1;
  localparam [2:0] PH_VBP  = 3'h2;
  localparam [2:0] PH_ACT  = 3'h3;
  localparam [2:0] PH_VFP  = 3'h4;
  localparam [2:0] PH_FE   = 3'h5;
  localparam [2:0] PH_TAIL = 3'h6;

  localparam [22:0] CLK_STEP = `TPG_CLK_THIRDS;
  localparam [7:0]  RST_CTL  = `TPG_RST_CONTROL;
  localparam [7:0]  RST_CFG  = `TPG_RST_CONFIG;
  localparam [7:0]  RST_ID   = `TPG_RST_IDENT;

  // ==========================================================
  // programmed settings
  reg         generator_on_reg;
  reg         fixed_colour_select_reg;
  reg  [1:0]  bar_count_code_reg;
  reg  [3:0]  block_size_reg;
  reg  [1:0]  packet_virtual_channel_reg;
  reg  [5:0]  packet_data_type_reg;
  reg  [15:0] active_line_bytes_reg;
  reg  [15:0] colour_bar_bytes_reg;
  reg  [15:0] active_lines_per_frame_reg;
  reg  [15:0] total_lines_per_frame_reg;
  reg  [15:0] line_period_count_reg;
  reg  [7:0]  back_porch_lines_reg;
  reg  [7:0]  front_porch_lines_reg;
  wire [119:0] colour_flat;

  // ==========================================================
  // per-frame copies
  reg         sh_fixed_reg;
  reg  [1:0]  sh_bars_reg;
  reg  [3:0]  sh_blk_reg;
  reg  [1:0]  sh_vc_reg;
  reg  [5:0]  sh_dt_reg;
  reg  [15:0] sh_line_reg;
  reg  [15:0] sh_bar_reg;
  reg  [15:0] sh_act_reg;
  reg  [15:0] sh_tot_reg;
  reg  [7:0]  sh_vbp_reg;
  reg  [7:0]  sh_vfp_reg;
  reg  [21:0] sh_target_reg;
  wire [119:0] sh_colour_flat;

  // ==========================================================
  // sequencer and byte engine state
  reg  [2:0]  phase_reg;
  reg  [15:0] line_idx_reg;
  reg  [22:0] time_reg;
  reg         emit_reg;
  reg  [1:0]  emit_kind_reg;
  reg  [15:0] byte_cnt_reg;
  reg  [2:0]  bar_idx_reg;
  reg  [15:0] bar_pos_reg;
  reg  [3:0]  blk_pos_reg;
  reg  [2:0]  next_phase;
  reg  [5:0]  unit_thirds;
  reg  [7:0]  read_mux;

  wire [16:0] n_line;
  wire [16:0] first_act;
  wire [16:0] first_vfp;
  wire [16:0] fe_line;
  wire        frame_over;
  wire        line_done;
  wire        begin_frame;
  wire        start_long;
  wire        start_fe;
  wire [21:0] target_calc;
  wire [2:0]  last_bar;
  wire [3:0]  col_sel;
  wire        is_long;
  wire        word_first;
  wire        word_last;
  wire [7:0]  word_byte;
  wire [19:0] word;
  wire        fifo_in_ready;
  wire        push;
  wire        fifo_out_valid;
  wire        fifo_out_ready;
  wire [19:0] fifo_out_data;

  // ==========================================================
  // register writes
  always @(posedge clock) begin
    if (srst) begin
      generator_on_reg           <= RST_CTL[`TPG_CTL_ON_BIT];
      fixed_colour_select_reg    <= RST_CFG[`TPG_CFG_FIXED_BIT];
      bar_count_code_reg         <=
        RST_CFG[`TPG_CFG_BARS_MSB:`TPG_CFG_BARS_LSB];
      block_size_reg             <=
        RST_CFG[`TPG_CFG_BLK_MSB:`TPG_CFG_BLK_LSB];
      packet_virtual_channel_reg <=
        RST_ID[`TPG_ID_VC_MSB:`TPG_ID_VC_LSB];
      packet_data_type_reg       <= RST_ID[`TPG_ID_DT_MSB:`TPG_ID_DT_LSB];
      active_line_bytes_reg      <= {`TPG_RST_LINE_HI, `TPG_RST_LINE_LO};
      colour_bar_bytes_reg       <= {`TPG_RST_BAR_HI, `TPG_RST_BAR_LO};
      active_lines_per_frame_reg <= {`TPG_RST_ACT_HI, `TPG_RST_ACT_LO};
      total_lines_per_frame_reg  <= {`TPG_RST_TOT_HI, `TPG_RST_TOT_LO};
      line_period_count_reg      <= {`TPG_RST_PD_HI, `TPG_RST_PD_LO};
      back_porch_lines_reg       <= `TPG_RST_VBP;
      front_porch_lines_reg      <= `TPG_RST_VFP;
    end else if (reg_wr) begin
      case (reg_addr)
        `TPG_OFF_CONTROL: begin
          generator_on_reg <= reg_wdata[`TPG_CTL_ON_BIT];
        end
        `TPG_OFF_CONFIG: begin
          fixed_colour_select_reg <= reg_wdata[`TPG_CFG_FIXED_BIT];
          bar_count_code_reg <=
            reg_wdata[`TPG_CFG_BARS_MSB:`TPG_CFG_BARS_LSB];
          block_size_reg <= reg_wdata[`TPG_CFG_BLK_MSB:`TPG_CFG_BLK_LSB];
        end
        `TPG_OFF_IDENT: begin
          packet_virtual_channel_reg <=
            reg_wdata[`TPG_ID_VC_MSB:`TPG_ID_VC_LSB];
          packet_data_type_reg <= reg_wdata[`TPG_ID_DT_MSB:`TPG_ID_DT_LSB];
        end
        `TPG_OFF_LINE_HI: active_line_bytes_reg[15:8] <= reg_wdata;
        `TPG_OFF_LINE_LO: active_line_bytes_reg[7:0] <= reg_wdata;
        `TPG_OFF_BAR_HI:  colour_bar_bytes_reg[15:8] <= reg_wdata;
        `TPG_OFF_BAR_LO:  colour_bar_bytes_reg[7:0] <= reg_wdata;
        `TPG_OFF_ACT_HI:  active_lines_per_frame_reg[15:8] <= reg_wdata;
        `TPG_OFF_ACT_LO:  active_lines_per_frame_reg[7:0] <= reg_wdata;
        `TPG_OFF_TOT_HI:  total_lines_per_frame_reg[15:8] <= reg_wdata;
        `TPG_OFF_TOT_LO:  total_lines_per_frame_reg[7:0] <= reg_wdata;
        `TPG_OFF_PD_HI:   line_period_count_reg[15:8] <= reg_wdata;
        `TPG_OFF_PD_LO:   line_period_count_reg[7:0] <= reg_wdata;
        `TPG_OFF_VBP:     back_porch_lines_reg <= reg_wdata;
        `TPG_OFF_VFP:     front_porch_lines_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // colour bytes and their per-frame copies
  genvar gi;
  generate
    for (gi = 0; gi < `TPG_NUM_COLOURS; gi = gi + 1) begin : g_colour
      localparam [7:0] ADDR = `TPG_OFF_COLOUR_BASE + gi;
      localparam [3:0] IDX  = gi;
      localparam [7:0] RST  = (gi == 0) ? `TPG_RST_COLOUR0 : {IDX, IDX};
      reg [7:0] byte_reg;
      reg [7:0] sh_byte_reg;
      always @(posedge clock) begin
        if (srst) begin
          byte_reg    <= RST;
          sh_byte_reg <= RST;
        end else begin
          if (reg_wr && reg_addr == ADDR) begin
            byte_reg <= reg_wdata;
          end
          if (begin_frame) begin
            sh_byte_reg <= byte_reg;
          end
        end
      end
      assign colour_flat[gi*8 +: 8]    = byte_reg;
      assign sh_colour_flat[gi*8 +: 8] = sh_byte_reg;
    end
  endgenerate

  // ==========================================================
  // register reads
  always @* begin
    read_mux = 8'h00;
    case (reg_addr)
      `TPG_OFF_CONTROL: read_mux = {7'h00, generator_on_reg};
      `TPG_OFF_CONFIG:  read_mux = {fixed_colour_select_reg, 1'b0,
                                    bar_count_code_reg, block_size_reg};
      `TPG_OFF_IDENT:   read_mux = {packet_virtual_channel_reg,
                                    packet_data_type_reg};
      `TPG_OFF_LINE_HI: read_mux = active_line_bytes_reg[15:8];
      `TPG_OFF_LINE_LO: read_mux = active_line_bytes_reg[7:0];
      `TPG_OFF_BAR_HI:  read_mux = colour_bar_bytes_reg[15:8];
      `TPG_OFF_BAR_LO:  read_mux = colour_bar_bytes_reg[7:0];
      `TPG_OFF_ACT_HI:  read_mux = active_lines_per_frame_reg[15:8];
      `TPG_OFF_ACT_LO:  read_mux = active_lines_per_frame_reg[7:0];
      `TPG_OFF_TOT_HI:  read_mux = total_lines_per_frame_reg[15:8];
      `TPG_OFF_TOT_LO:  read_mux = total_lines_per_frame_reg[7:0];
      `TPG_OFF_PD_HI:   read_mux = line_period_count_reg[15:8];
      `TPG_OFF_PD_LO:   read_mux = line_period_count_reg[7:0];
      `TPG_OFF_VBP:     read_mux = back_porch_lines_reg;
      `TPG_OFF_VFP:     read_mux = front_porch_lines_reg;
      `TPG_OFF_STATUS:  read_mux = {5'h00, phase_reg};
      default: begin
        if (reg_addr[7:4] == 4'h1) begin
          read_mux = colour_flat[{reg_addr[3:0], 3'h0} +: 8];
        end
      end
    endcase
  end

  always @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end
  end

  // ==========================================================
  // line period in thirds of a nanosecond
  always @* begin
    case (csi_rate_sel)
      `TPG_RATE_1G2:  unit_thirds = `TPG_UNIT_MID_THIRDS;
      `TPG_RATE_400M: unit_thirds = `TPG_UNIT_SLOW_THIRDS;
      default:        unit_thirds = `TPG_UNIT_FAST_THIRDS;
    endcase
  end

  assign target_calc = {6'h00, line_period_count_reg} *
                       {16'h0000, unit_thirds};

  // ==========================================================
  // frame sequencing
  assign n_line    = {1'b0, line_idx_reg} + 17'h00001;
  assign first_act = 17'h00001 + {9'h000, sh_vbp_reg};
  assign first_vfp = first_act + {1'b0, sh_act_reg};
  assign fe_line   = first_vfp + {9'h000, sh_vfp_reg};
  assign frame_over = (n_line >= {1'b0, sh_tot_reg}) &&
                      (n_line > fe_line);
  assign line_done = (phase_reg != PH_IDLE) && !emit_reg &&
                     (time_reg >= {1'b0, sh_target_reg});
  assign begin_frame = generator_on_reg &&
                       ((phase_reg == PH_IDLE) || (line_done && frame_over));
  assign start_long = line_done && !frame_over && (next_phase == PH_ACT) &&
                      (sh_line_reg != 16'h0000);
  assign start_fe = line_done && !frame_over && (next_phase == PH_FE);

  always @* begin
    next_phase = PH_TAIL;
    if (n_line < first_act) begin
      next_phase = PH_VBP;
    end else if (n_line < first_vfp) begin
      next_phase = PH_ACT;
    end else if (n_line < fe_line) begin
      next_phase = PH_VFP;
    end else if (n_line == fe_line) begin
      next_phase = PH_FE;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      sh_fixed_reg  <= 1'b0;
      sh_bars_reg   <= 2'h0;
      sh_blk_reg    <= 4'h0;
      sh_vc_reg     <= 2'h0;
      sh_dt_reg     <= 6'h00;
      sh_line_reg   <= 16'h0000;
      sh_bar_reg    <= 16'h0000;
      sh_act_reg    <= 16'h0000;
      sh_tot_reg    <= 16'h0000;
      sh_vbp_reg    <= 8'h00;
      sh_vfp_reg    <= 8'h00;
      sh_target_reg <= 22'h000000;
    end else if (begin_frame) begin
      sh_fixed_reg  <= fixed_colour_select_reg;
      sh_bars_reg   <= bar_count_code_reg;
      sh_blk_reg    <= block_size_reg;
      sh_vc_reg     <= packet_virtual_channel_reg;
      sh_dt_reg     <= packet_data_type_reg;
      sh_line_reg   <= active_line_bytes_reg;
      sh_bar_reg    <= colour_bar_bytes_reg;
      sh_act_reg    <= active_lines_per_frame_reg;
      sh_tot_reg    <= total_lines_per_frame_reg;
      sh_vbp_reg    <= back_porch_lines_reg;
      sh_vfp_reg    <= front_porch_lines_reg;
      sh_target_reg <= target_calc;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      phase_reg    <= PH_IDLE;
      line_idx_reg <= 16'h0000;
      time_reg     <= 23'h000000;
      frame_active <= 1'b0;
    end else begin
      frame_active <= (phase_reg != PH_IDLE);
      if (begin_frame) begin
        phase_reg    <= PH_FS;
        line_idx_reg <= 16'h0000;
        time_reg     <= 23'h000000;
      end else if (line_done && frame_over) begin
        phase_reg <= PH_IDLE;
        time_reg  <= 23'h000000;
      end else if (line_done) begin
        phase_reg    <= next_phase;
        line_idx_reg <= n_line[15:0];
        time_reg     <= 23'h000000;
      end else if (phase_reg != PH_IDLE &&
                   time_reg < {1'b0, sh_target_reg}) begin
        time_reg <= time_reg + CLK_STEP;
      end
    end
  end

  // ==========================================================
  // byte engine
  // 3-bit wrap turns 1<<3 into 0, so code 11 gives index 7
  assign last_bar   = (3'h1 << sh_bars_reg) - 3'h1;
  assign col_sel    = sh_fixed_reg ? blk_pos_reg :
                      {1'b0, bar_idx_reg};
  assign is_long    = (emit_kind_reg == `TPG_KIND_LONG);
  assign word_first = !is_long || (byte_cnt_reg == 16'h0000);
  assign word_last  = !is_long ||
                      (byte_cnt_reg == sh_line_reg - 16'h0001);
  assign word_byte  = is_long ?
                      sh_colour_flat[{col_sel, 3'h0} +: 8] : 8'h00;
  assign word       = {sh_vc_reg, sh_dt_reg, emit_kind_reg,
                       word_first, word_last, word_byte};
  assign push       = emit_reg && fifo_in_ready;

  always @(posedge clock) begin
    if (srst) begin
      emit_reg      <= 1'b0;
      emit_kind_reg <= `TPG_KIND_FS;
      byte_cnt_reg  <= 16'h0000;
      bar_idx_reg   <= 3'h0;
      bar_pos_reg   <= 16'h0000;
      blk_pos_reg   <= 4'h0;
    end else if (begin_frame) begin
      emit_reg      <= 1'b1;
      emit_kind_reg <= `TPG_KIND_FS;
    end else if (start_fe) begin
      emit_reg      <= 1'b1;
      emit_kind_reg <= `TPG_KIND_FE;
    end else if (start_long) begin
      emit_reg      <= 1'b1;
      emit_kind_reg <= `TPG_KIND_LONG;
      byte_cnt_reg  <= 16'h0000;
      bar_idx_reg   <= 3'h0;
      bar_pos_reg   <= 16'h0000;
      blk_pos_reg   <= 4'h0;
    end else if (push) begin
      if (word_last) begin
        emit_reg <= 1'b0;
      end else begin
        byte_cnt_reg <= byte_cnt_reg + 16'h0001;
        // last bar never advances, so it runs to line end
        if (bar_pos_reg == sh_bar_reg - 16'h0001 &&
            bar_idx_reg != last_bar) begin
          bar_idx_reg <= bar_idx_reg + 3'h1;
          bar_pos_reg <= 16'h0000;
        end else begin
          bar_pos_reg <= bar_pos_reg + 16'h0001;
        end
        if (blk_pos_reg + 4'h1 >= sh_blk_reg) begin
          blk_pos_reg <= 4'h0;
        end else begin
          blk_pos_reg <= blk_pos_reg + 4'h1;
        end
      end
    end
  end

  // ==========================================================
  // buffer and output stage
  tpg_fifo #(
    .W     (`TPG_WORD_W),
    .DEPTH (`TPG_FIFO_DEPTH),
    .AW    (`TPG_FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (emit_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  assign fifo_out_ready = !out_valid || out_ready;

  always @(posedge clock) begin
    if (srst) begin
      out_valid <= 1'b0;
      out_vc    <= 2'h0;
      out_dt    <= 6'h00;
      out_kind  <= 2'h0;
      out_first <= 1'b0;
      out_last  <= 1'b0;
      out_data  <= 8'h00;
    end else if (fifo_out_ready) begin
      out_valid <= fifo_out_valid;
      if (fifo_out_valid) begin
        out_vc    <= fifo_out_data[19:18];
        out_dt    <= fifo_out_data[17:12];
        out_kind  <= fifo_out_data[11:10];
        out_first <= fifo_out_data[9];
        out_last  <= fifo_out_data[8];
        out_data  <= fifo_out_data[7:0];
      end
    end
  end

endmodule

`default_nettype wire

// ==== tpg_map.vh ====
/*
 * Register offsets, field positions, reset values, packet kinds and
 * timing constants of the test pattern generator register page.
 * Assumes it is included by bare name from the generator files.
 */
`ifndef TPG_MAP_VH
`define TPG_MAP_VH

// ==========================================================
// register offsets within the indirect page
`define TPG_OFF_CONTROL     8'h01
`define TPG_OFF_CONFIG      8'h02
`define TPG_OFF_IDENT       8'h03
`define TPG_OFF_LINE_HI     8'h04
`define TPG_OFF_LINE_LO     8'h05
`define TPG_OFF_BAR_HI      8'h06
`define TPG_OFF_BAR_LO      8'h07
`define TPG_OFF_ACT_HI      8'h08
`define TPG_OFF_ACT_LO      8'h09
`define TPG_OFF_TOT_HI      8'h0a
`define TPG_OFF_TOT_LO      8'h0b
`define TPG_OFF_PD_HI       8'h0c
`define TPG_OFF_PD_LO       8'h0d
`define TPG_OFF_VBP         8'h0e
`define TPG_OFF_VFP         8'h0f
`define TPG_OFF_COLOUR_BASE 8'h10
`define TPG_OFF_STATUS      8'h1f
`define TPG_NUM_COLOURS     15

// ==========================================================
// field positions
`define TPG_CTL_ON_BIT      0
`define TPG_CFG_FIXED_BIT   7
`define TPG_CFG_BARS_MSB    5
`define TPG_CFG_BARS_LSB    4
`define TPG_CFG_BLK_MSB     3
`define TPG_CFG_BLK_LSB     0
`define TPG_ID_VC_MSB       7
`define TPG_ID_VC_LSB       6
`define TPG_ID_DT_MSB       5
`define TPG_ID_DT_LSB       0

// ==========================================================
// reset values
`define TPG_RST_CONTROL     8'h00
`define TPG_RST_CONFIG      8'h33
`define TPG_RST_IDENT       8'h24
`define TPG_RST_LINE_HI     8'h07
`define TPG_RST_LINE_LO     8'h80
`define TPG_RST_BAR_HI      8'h00
`define TPG_RST_BAR_LO      8'hf0
`define TPG_RST_ACT_HI      8'h01
`define TPG_RST_ACT_LO      8'he0
`define TPG_RST_TOT_HI      8'h02
`define TPG_RST_TOT_LO      8'h0d
`define TPG_RST_PD_HI       8'h0c
`define TPG_RST_PD_LO       8'h67
`define TPG_RST_VBP         8'h21
`define TPG_RST_VFP         8'h0a
`define TPG_RST_COLOUR0     8'haa

// ==========================================================
// output rate codes and packet kinds
`define TPG_RATE_1G6        2'h0
`define TPG_RATE_1G2        2'h1
`define TPG_RATE_800M       2'h2
`define TPG_RATE_400M       2'h3
`define TPG_KIND_FS         2'h0
`define TPG_KIND_FE         2'h1
`define TPG_KIND_LONG       2'h2

// ==========================================================
// timing, in thirds of a nanosecond so 13.33 ns stays exact
`define TPG_CLK_NS          50
`define TPG_CLK_THIRDS      (3 * `TPG_CLK_NS)
`define TPG_UNIT_FAST_NS    10
`define TPG_UNIT_MID_THIRDS 40
`define TPG_UNIT_SLOW_NS    20
`define TPG_UNIT_FAST_THIRDS (3 * `TPG_UNIT_FAST_NS)
`define TPG_UNIT_SLOW_THIRDS (3 * `TPG_UNIT_SLOW_NS)

// ==========================================================
// buffer shape
`define TPG_WORD_W          20
`define TPG_FIFO_DEPTH      4
`define TPG_FIFO_AW         2

`endif

// ==== tpg_fifo.v ====
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module tpg_fifo #(
  parameter W     = 20,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire         clock,
  input  wire         srst,
  // fill side
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg  [W-1:0] mem [0:DEPTH-1];
  reg  [AW:0]  wr_ptr_reg;
  reg  [AW:0]  rd_ptr_reg;
  wire         full;
  wire         empty;
  wire         push;
  wire         pop;

  assign full      = (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]) &&
                     (wr_ptr_reg[AW] != rd_ptr_reg[AW]);
  assign empty     = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      wr_ptr_reg <= {(AW+1){1'b0}};
      rd_ptr_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tpg_checker.sv ====
/* tpg_checker: stream and register assertions on tpg_generator.
   Assumes a bind to the generator ports, one clock, srst active high. */
`timescale 1ns/100ps
`default_nettype none
module tpg_checker (
  // clock and reset
  input wire logic       clock,
  input wire logic       srst,
  // register page
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  // stream
  input wire logic       out_valid,
  input wire logic       out_ready,
  input wire logic [1:0] out_kind,
  input wire logic       out_first,
  input wire logic       out_last,
  input wire logic [1:0] out_vc,
  input wire logic [5:0] out_dt,
  input wire logic [7:0] out_data,
  input wire logic       frame_active
);
  // ==========
  // frame and packet tracking
  logic       in_frame_reg;
  logic       mid_reg;
  logic [7:0] id_reg;
  always_ff @(posedge clock) begin
    if (srst) begin
      in_frame_reg <= 1'b0;
      mid_reg <= 1'b0;
      id_reg <= 8'h00;
    end else if (out_valid && out_ready) begin
      if (out_kind == 2'h0) begin
        in_frame_reg <= 1'b1;
        id_reg <= {out_vc, out_dt};
      end
      if (out_kind == 2'h1) in_frame_reg <= 1'b0;
      if (out_kind == 2'h2) mid_reg <= !out_last;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  chk_rst_quiet: assert property (
    $fell(srst) |-> !out_valid && !frame_active)
    else $error("stream active after reset");
  chk_stall_hold: assert property (
    out_valid && !out_ready |=> out_valid && $stable({out_kind, out_first,
      out_last, out_vc, out_dt, out_data}))
    else $error("word changed while stalled");
  chk_short_form: assert property (
    out_valid && out_kind != 2'h2 |-> out_first && out_last && !out_data)
    else $error("short packet malformed");
  chk_fs_outside: assert property (
    out_valid && out_kind == 2'h0 |-> !in_frame_reg)
    else $error("frame start inside frame");
  chk_body_inside: assert property (
    out_valid && out_kind != 2'h0 |-> in_frame_reg)
    else $error("word outside frame");
  chk_first_flag: assert property (
    out_valid && out_kind == 2'h2 |-> out_first == !mid_reg)
    else $error("first flag misplaced");
  chk_id_steady: assert property (
    out_valid && out_kind != 2'h0 |-> {out_vc, out_dt} == id_reg)
    else $error("packet ident changed in frame");
  chk_ctl_reserved: assert property (
    reg_rd && reg_addr == 8'h01 |=> reg_rdata[7:1] == 7'h00)
    else $error("control reserved bits set");
  chk_cfg_reserved: assert property (
    reg_rd && reg_addr == 8'h02 |=> !reg_rdata[6])
    else $error("config reserved bit set");
endmodule
bind tpg_generator tpg_checker chk (.clock(clock), .srst(srst),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind),
  .out_first(out_first), .out_last(out_last), .out_vc(out_vc),
  .out_dt(out_dt), .out_data(out_data), .frame_active(frame_active));
`default_nettype wire

// ==== tpg_sink.sv ====
/* tpg_sink: transmit side taking the pattern stream.
   Assumes the bench sets stall_on; ready moves 2 ns after an edge. */
`timescale 1ns/100ps
`default_nettype none
module tpg_sink (
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // bench control
  input wire logic stall_on,
  // handshake
  output var logic out_ready
);
  integer seed = 32'h0c1714e8;
  initial out_ready = 1'b0;
  // random back pressure while stalling
  always @(posedge clock) begin
    #2 out_ready = !srst && (!stall_on || ($random(seed) & 1) == 1);
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
/* testbench: drives the pattern page and compares the stream with a
   frame model. Assumes tpg_generator, tpg_sink and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic stall_on = 1'b0, fx;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, out_data;
  logic [1:0] csi_rate_sel = 2'h0, out_kind, out_vc, code, vc;
  logic [5:0] out_dt, dt;
  logic [3:0] blk;
  logic out_valid, out_ready, out_first, out_last, frame_active;
  integer bad_count = 0, total_checks = 0, cycles = 0;
  integer seed = 32'h0c1714e8, i, j, k, n;
  logic [7:0] col [0:14];
  logic [19:0] got [$], exp [$];
  logic [7:0] rst_val [0:15] = '{8'h00, 8'h00, 8'h33, 8'h24, 8'h07,
    8'h80, 8'h00, 8'hf0, 8'h01, 8'he0, 8'h02, 8'h0d, 8'h0c, 8'h67,
    8'h21, 8'h0a};
  logic [7:0] setup [4:15] = '{8'h00, 8'd30, 8'h00, 8'd3, 8'h00, 8'd2,
    8'h00, 8'd3, 8'h00, 8'd5, 8'd1, 8'd1};
  tpg_generator dut (.clock(clock), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .csi_rate_sel(csi_rate_sel),
    .out_valid(out_valid), .out_ready(out_ready), .out_kind(out_kind),
    .out_first(out_first), .out_last(out_last), .out_vc(out_vc),
    .out_dt(out_dt), .out_data(out_data), .frame_active(frame_active));
  tpg_sink sink (.clock(clock), .srst(srst), .stall_on(stall_on),
    .out_ready(out_ready));
  initial forever #25 clock = ~clock;
  // ==========
  // collection and hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (out_valid === 1'b1 && out_ready === 1'b1)
      got.push_back({out_kind, out_first, out_last, out_vc, out_dt, out_data});
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      close_out();
    end
  end
  task automatic check(input logic [19:0] g, e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      bad_count = bad_count + 1;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clock);
    #2 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #2 reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clock);
    #2 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #2 reg_rd = 1'b0;
    check({12'h000, reg_rdata}, {12'h000, e});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (6) @(posedge clock);
    #2 srst = 1'b0;
    for (k = 0; k < 16; k++) rd(k[7:0], rst_val[k]);
    rd(8'h10, 8'haa);
    for (k = 0; k < 15; k++) begin
      col[k] = 8'($random(seed));
      wr(8'h10 + k[7:0], col[k]);
      rd(8'h10 + k[7:0], col[k]);
    end
    for (k = 4; k < 16; k++) wr(k[7:0], setup[k]);
    for (i = 0; i < 6; i++) begin
      fx = i > 3;
      code = i[1:0];
      blk = (i == 4) ? 4'd1 : 4'd15;
      vc = i[1:0];
      dt = 6'($random(seed));
      n = 1 << code;
      stall_on = i[0];
      csi_rate_sel = i[1:0];
      wr(8'h02, {fx, 1'b0, code, blk});
      wr(8'h03, {vc, dt});
      exp.delete();
      got.delete();
      exp.push_back({4'h3, vc, dt, 8'h00});
      for (j = 0; j < 2; j++)
        for (k = 0; k < 30; k++)
          exp.push_back({2'h2, k == 0, k == 29, vc, dt,
            col[fx ? k % blk : (k / 3 < n ? k / 3 : n - 1)]});
      exp.push_back({4'h7, vc, dt, 8'h00});
      wr(8'h01, 8'h01);
      while (got.size() == 0) @(posedge clock);
      wr(8'h03, 8'($random(seed)));
      check({19'h00000, frame_active}, 20'h00001);
      wr(8'h01, 8'h00);
      while (got.size() < exp.size()) @(posedge clock);
      repeat (300) @(posedge clock);
      check(20'(got.size()), 20'(exp.size()));
      rd(8'h1f, 8'h00);
      check({19'h00000, frame_active}, 20'h00000);
      for (k = 0; k < exp.size(); k++) check(got[k], exp[k]);
    end
    close_out();
  end
endmodule
`default_nettype wire
